// ### core/tx_overhead_insert_port.sv
// transmit overhead data input port of one framer channel
// assumes the framer core runs on clk_i and announces each overhead bit one
// transmit bit period ahead; transmit_input_clock and all far-end pins are
// asynchronous and are synchronised here before use
//
// How it works
// - accepted bit goes to matching frame position
// - strobe high: sample data at transmit clock rise
// - strobe low: ignore data, keep internal bit
// - insertion on non-insertable bit is discarded
// - enable high one transmit clock, before sampling
// - data latched at next transmit rising edge
// - hdlc on: pins carry bits 5,4,7
// - overhead clock rises one bit ahead
`timescale 1ns/1ps

module tx_overhead_insert_port
  import tx_oh_pkg::*;
(
  input wire logic clk_i,                             // 25 MHz system clock
  input wire logic rst_n_i,                           // asynchronous reset, active low
  input wire logic transmit_input_clock_i,            // transmit input clock pin
  input wire logic tx_overhead_data_in_i,             // overhead data pin
  input wire logic tx_overhead_insert_strobe_i,       // insert strobe pin
  input wire logic tx_overhead_input_enable_in_i,     // enable pin, read in hdlc mode
  output logic tx_overhead_input_enable_out_o,        // enable pin, driven value
  output logic tx_overhead_input_enable_oe_o,         // enable pin, output enable
  output logic tx_overhead_clock_out_o,               // overhead clock pin
  input wire logic oh_announce_i,                     // core: next bit is overhead
  input wire logic oh_insertable_i,                   // core: that bit may be supplied
  input wire logic oh_internal_bit_i,                 // core: internally made value
  input wire logic hdlc_on_i,                         // core: hdlc controller turned on
  output logic oh_bit_o,                              // overhead bit back to core
  output logic oh_bit_valid_o,                        // one-cycle pulse with oh_bit_o
  output logic oh_bit_inserted_o,                     // bit came from the far end
  output logic [HDLC_SLICE_W-1:0] tx_hdlc_parallel_data_o, // bits 7,5,4 of hdlc word
  output logic tx_hdlc_data_valid_o                   // one-cycle pulse with hdlc bits
);

  // two-flop synchronisers for the asynchronous pins
  logic tclk_meta_reg;          // transmit clock, first stage
  logic tclk_sync_reg;          // transmit clock, second stage
  logic tclk_prev_reg;          // transmit clock, delayed for edge find
  logic data_meta_reg;          // data pin, first stage
  logic data_sync_reg;          // data pin, second stage
  logic strobe_meta_reg;        // strobe pin, first stage
  logic strobe_sync_reg;        // strobe pin, second stage
  logic enin_meta_reg;          // enable pin as input, first stage
  logic enin_sync_reg;          // enable pin as input, second stage

  // sequencer and output state
  oh_state_e state_reg;         // insertion sequencer state
  oh_state_e state_next;
  logic insertable_reg;         // latched insertable flag of the announced bit
  logic insertable_next;
  logic internal_reg;           // latched internal value of the announced bit
  logic internal_next;
  logic ohclk_reg;              // overhead clock level
  logic ohclk_next;
  logic bit_reg;                // bit handed to the core
  logic bit_next;
  logic valid_reg;              // valid pulse to the core
  logic valid_next;
  logic inserted_reg;           // inserted flag to the core
  logic inserted_next;
  logic [HDLC_SLICE_W-1:0] hdlc_reg; // hdlc slice to the controller
  logic [HDLC_SLICE_W-1:0] hdlc_next;
  logic hdlc_valid_reg;         // hdlc slice valid pulse
  logic hdlc_valid_next;

  // rising edge of the synchronised transmit clock
  logic tx_rise;
  // the far end supplies this bit
  logic take_external;

  // synchronisers: only the second stages and tclk_prev_reg are read by logic
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tclk_meta_reg <= 1'b0;
      tclk_sync_reg <= 1'b0;
      tclk_prev_reg <= 1'b0;
      data_meta_reg <= 1'b0;
      data_sync_reg <= 1'b0;
      strobe_meta_reg <= 1'b0;
      strobe_sync_reg <= 1'b0;
      enin_meta_reg <= 1'b0;
      enin_sync_reg <= 1'b0;
    end
    else
    begin
      tclk_meta_reg <= transmit_input_clock_i;
      tclk_sync_reg <= tclk_meta_reg;
      tclk_prev_reg <= tclk_sync_reg;
      data_meta_reg <= tx_overhead_data_in_i;
      data_sync_reg <= data_meta_reg;
      strobe_meta_reg <= tx_overhead_insert_strobe_i;
      strobe_sync_reg <= strobe_meta_reg;
      enin_meta_reg <= tx_overhead_input_enable_in_i;
      enin_sync_reg <= enin_meta_reg;
    end
  end

  // transmit clock edge, seen after the synchroniser delay; data and strobe
  // pass the same two stages, so they stay aligned with this edge
  assign tx_rise = tclk_sync_reg & ~tclk_prev_reg;

  assign take_external = strobe_sync_reg & insertable_reg & ~hdlc_on_i;

  // next-state logic of the sequencer and its outputs
  always_comb
  begin
    state_next = state_reg;
    insertable_next = insertable_reg;
    internal_next = internal_reg;
    ohclk_next = ohclk_reg;
    bit_next = bit_reg;
    valid_next = 1'b0;
    inserted_next = inserted_reg;
    case (state_reg)
      ST_IDLE:
      begin
        // an overhead bit is coming in the next bit period
        if (tx_rise && oh_announce_i)
        begin
          state_next = ST_ANNOUNCE;
          insertable_next = oh_insertable_i;
          internal_next = oh_internal_bit_i;
          ohclk_next = 1'b1;
        end
      end
      ST_ANNOUNCE:
      begin
        if (tx_rise)
        begin
          // overhead clock falls at the sampling instant
          ohclk_next = 1'b0;
          valid_next = 1'b1;
          if (take_external)
          begin
            bit_next = data_sync_reg;
            inserted_next = 1'b1;
          end
          else
          begin
            bit_next = internal_reg;
            inserted_next = 1'b0;
          end
          // back-to-back overhead bits start a new announcement at once
          if (oh_announce_i)
          begin
            state_next = ST_ANNOUNCE;
            insertable_next = oh_insertable_i;
            internal_next = oh_internal_bit_i;
            ohclk_next = 1'b1;
          end
          else
          begin
            state_next = ST_IDLE;
          end
        end
      end
      default:
      begin
        state_next = ST_IDLE;
        ohclk_next = RST_OH_CLOCK;
      end
    endcase
  end

  // next values of the hdlc slice; pins as bits 7,5,4
  always_comb
  begin
    hdlc_next = hdlc_reg;
    hdlc_valid_next = 1'b0;
    // one slice per transmit clock while the hdlc controller is on
    if (hdlc_on_i && tx_rise)
    begin
      hdlc_next = {enin_sync_reg, data_sync_reg, strobe_sync_reg};
      hdlc_valid_next = 1'b1;
    end
  end

  // registers of the sequencer and the hdlc slice
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= ST_IDLE;
      insertable_reg <= 1'b0;
      internal_reg <= RST_BIT;
      ohclk_reg <= RST_OH_CLOCK;
      bit_reg <= RST_BIT;
      valid_reg <= 1'b0;
      inserted_reg <= 1'b0;
      hdlc_reg <= RST_HDLC;
      hdlc_valid_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      insertable_reg <= insertable_next;
      internal_reg <= internal_next;
      ohclk_reg <= ohclk_next;
      bit_reg <= bit_next;
      valid_reg <= valid_next;
      inserted_reg <= inserted_next;
      hdlc_reg <= hdlc_next;
      hdlc_valid_reg <= hdlc_valid_next;
    end
  end

  assign tx_overhead_input_enable_out_o = (state_reg == ST_ANNOUNCE);
  // enable pin is an input in hdlc mode
  assign tx_overhead_input_enable_oe_o = ~hdlc_on_i;
  assign tx_overhead_clock_out_o = ohclk_reg;
  assign oh_bit_o = bit_reg;
  assign oh_bit_valid_o = valid_reg;
  assign oh_bit_inserted_o = inserted_reg;
  assign tx_hdlc_parallel_data_o = hdlc_reg;
  assign tx_hdlc_data_valid_o = hdlc_valid_reg;

  // assertions guarding the insertion handshake

  // an announced bit reaching its sampling edge
  sequence s_sample_edge;
    (state_reg == ST_ANNOUNCE) && tx_rise;
  endsequence

  // enable is raised by a transmit clock rise with an announcement
  sequence s_enable_start;
    $rose(tx_overhead_input_enable_out_o);
  endsequence

  property p_enable_one_period;
    @(posedge clk_i) disable iff (!rst_n_i)
    $fell(tx_overhead_input_enable_out_o) |-> $past(tx_rise);
  endproperty
  a_enable_one_period: assert property (p_enable_one_period)
    else $error("enable dropped away from a transmit clock rise");

  property p_enable_bounded;
    @(posedge clk_i) disable iff (!rst_n_i)
    (s_enable_start |-> $past(tx_rise) && $past(oh_announce_i))
      and ((s_sample_edge ##0 !oh_announce_i) |=> !tx_overhead_input_enable_out_o);
  endproperty
  a_enable_bounded: assert property (p_enable_bounded)
    else $error("enable not confined to one transmit clock period");

  property p_sample_external;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_sample_edge ##0 (strobe_sync_reg && insertable_reg && !hdlc_on_i)
      |=> oh_bit_valid_o && oh_bit_inserted_o && (oh_bit_o == $past(data_sync_reg));
  endproperty
  a_sample_external: assert property (p_sample_external)
    else $error("strobed data not latched at the sampling edge");

  property p_ignore_unstrobed;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_sample_edge ##0 !strobe_sync_reg
      |=> oh_bit_valid_o && !oh_bit_inserted_o && (oh_bit_o == $past(internal_reg));
  endproperty
  a_ignore_unstrobed: assert property (p_ignore_unstrobed)
    else $error("data taken without the insert strobe");

  property p_discard_fixed;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_sample_edge ##0 !insertable_reg |=> !oh_bit_inserted_o;
  endproperty
  a_discard_fixed: assert property (p_discard_fixed)
    else $error("non-insertable overhead bit was overwritten");

  property p_clock_leads;
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(tx_overhead_clock_out_o) |-> tx_overhead_input_enable_out_o && $past(tx_rise);
  endproperty
  a_clock_leads: assert property (p_clock_leads)
    else $error("overhead clock rose outside an announcement");

  property p_valid_after_enable;
    @(posedge clk_i) disable iff (!rst_n_i)
    oh_bit_valid_o |-> $past(state_reg == ST_ANNOUNCE) && $past(tx_rise);
  endproperty
  a_valid_after_enable: assert property (p_valid_after_enable)
    else $error("overhead bit delivered without an announcement");

  property p_hdlc_no_insert;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_sample_edge ##0 hdlc_on_i |=> !oh_bit_inserted_o;
  endproperty
  a_hdlc_no_insert: assert property (p_hdlc_no_insert)
    else $error("insertion active while hdlc controller is on");

  property p_hdlc_slice;
    @(posedge clk_i) disable iff (!rst_n_i)
    (hdlc_on_i && tx_rise) |=> tx_hdlc_data_valid_o
      && (tx_hdlc_parallel_data_o == {$past(enin_sync_reg), $past(data_sync_reg),
          $past(strobe_sync_reg)}) && !tx_overhead_input_enable_oe_o;
  endproperty
  a_hdlc_slice: assert property (p_hdlc_slice)
    else $error("hdlc slice not taken from the shared pins");

endmodule : tx_overhead_insert_port

// ### core/tx_oh_pkg.sv
// package for the transmit overhead insert port
// shared constants and state type; used by tx_overhead_insert_port, also imported by tb_top
package tx_oh_pkg;

  // position of each shared pin within the parallel hdlc transmit word
  localparam int unsigned HDLC_POS_DATA = 5;
  localparam int unsigned HDLC_POS_STROBE = 4;
  localparam int unsigned HDLC_POS_ENABLE = 7;

  // width of the hdlc slice carried on the shared pins
  localparam int unsigned HDLC_SLICE_W = 3;

  // reset values of the port outputs
  localparam logic RST_ENABLE = 1'b0;
  localparam logic RST_OH_CLOCK = 1'b0;
  localparam logic RST_BIT = 1'b0;
  localparam logic [2:0] RST_HDLC = 3'h0;

  // period of the bench transmit input clock, in ns, for reference
  localparam int unsigned TX_CLK_PERIOD_NS = 320;

  // insertion sequencer states
  typedef enum logic [0:0]
  {
    ST_IDLE = 1'b0,
    ST_ANNOUNCE = 1'b1
  } oh_state_e;

endpackage : tx_oh_pkg

// ### verification/oh_terminal_model.sv
// terminal equipment model facing the transmit overhead insert port
// assumes it sees the enable pin level and the free-running transmit clock
`timescale 1ns/1ps

module oh_terminal_model
(
  input wire logic tx_clk_i,          // transmit input clock
  input wire logic enable_i,          // enable pin level
  input wire logic want_i,            // insert the next announced bit
  input wire logic value_i,           // value to insert
  input wire logic hdlc_i,            // hdlc mode: pins carry data bits
  input wire logic [1:0] hdlc_bits_i, // {data, strobe} hdlc bits
  output logic data_o,                // overhead data pin
  output logic strobe_o               // insert strobe pin
);
  // pins start quiet
  initial
  begin
    data_o = 1'b0;
    strobe_o = 1'b0;
  end

  always @(negedge tx_clk_i)
  begin
    if (hdlc_i)
    begin
      data_o = hdlc_bits_i[1];
      strobe_o = hdlc_bits_i[0];
    end
    else if (enable_i && want_i)
    begin
      data_o = value_i;
      strobe_o = 1'b1;
    end
    else
    begin
      // released: show the inverse so a stale sample is caught
      data_o = ~data_o;
      strobe_o = 1'b0;
    end
  end
endmodule : oh_terminal_model

// ### verification/tb_top.sv
// self-checking bench for the transmit overhead insert port
// assumes core inputs change on clk_i and the link clock runs free at 320 ns
`timescale 1ns/1ps

module tb_top import tx_oh_pkg::*;;
  logic clk_i, rst_n_i, tx_clk, announce, insertable, internal_bit, hdlc_on, want, value;
  logic bench_en, data_pin, strobe_pin, en_out, en_oe, oh_clk, bit_o, bit_valid, bit_ins;
  logic hdlc_valid, en_wire, last_bit, last_ins;
  logic [1:0] hdlc_bits;
  logic [2:0] hdlc_data;
  logic [6:0] rows [5] = '{7'h2f, 7'h39, 7'h32, 7'h0c, 7'h6c}; // {in[4:0], bit, inserted}
  int num_errors, check_count, cycles, en_cnt, ck_cnt, val_cnt, i;

  // enable pin level: device drives it unless hdlc mode
  assign en_wire = en_oe ? en_out : bench_en;

  tx_overhead_insert_port tx_overhead_insert_port_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .transmit_input_clock_i(tx_clk), .tx_overhead_data_in_i(data_pin),
    .tx_overhead_insert_strobe_i(strobe_pin), .tx_overhead_input_enable_in_i(en_wire),
    .tx_overhead_input_enable_out_o(en_out), .tx_overhead_input_enable_oe_o(en_oe),
    .tx_overhead_clock_out_o(oh_clk), .oh_announce_i(announce), .oh_insertable_i(insertable),
    .oh_internal_bit_i(internal_bit), .hdlc_on_i(hdlc_on), .oh_bit_o(bit_o),
    .oh_bit_valid_o(bit_valid), .oh_bit_inserted_o(bit_ins),
    .tx_hdlc_parallel_data_o(hdlc_data), .tx_hdlc_data_valid_o(hdlc_valid));

  oh_terminal_model oh_terminal_model_inst (.tx_clk_i(tx_clk), .enable_i(en_wire),
    .want_i(want), .value_i(value), .hdlc_i(hdlc_on), .hdlc_bits_i(hdlc_bits),
    .data_o(data_pin), .strobe_o(strobe_pin));

  // system clock and link clock, link edges on clk falling edges, midway between rising edges
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial
  begin
    tx_clk = 1'b0;
    #40;
    forever #160 tx_clk = ~tx_clk;
  end

  // monitor on the falling edge, where the outputs have settled
  always @(negedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      report_and_stop();
    end
    if (en_out === 1'b1) en_cnt++;
    if (oh_clk === 1'b1) ck_cnt++;
    if (bit_valid === 1'b1)
    begin
      val_cnt++;
      last_bit = bit_o;
      last_ins = bit_ins;
    end
  end

  // compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // announce n back-to-back overhead bits, then check what came back
  task automatic run_op(input int n, input logic exp_bit, input logic exp_ins);
    en_cnt = 0;
    ck_cnt = 0;
    val_cnt = 0;
    @(posedge tx_clk);
    @(posedge clk_i) announce <= 1'b1;
    repeat (n) @(posedge tx_clk);
    @(posedge clk_i) announce <= 1'b0;
    repeat (12) @(posedge clk_i);
    if (hdlc_on === 1'b0) check(8'(en_cnt), 8'(8 * n));
    check(8'(ck_cnt), 8'(8 * n));
    check(8'(val_cnt), 8'(n));
    check({7'h0, last_bit}, {7'h0, exp_bit});
    check({7'h0, last_ins}, {7'h0, exp_ins});
  endtask : run_op

  // verdict and end of run
  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  // main sequence
  initial
  begin
    {rst_n_i, announce, insertable, internal_bit, hdlc_on, want, value, bench_en} = 8'h00;
    hdlc_bits = 2'h3;
    repeat (3) @(posedge clk_i);
    check({2'h0, en_out, oh_clk, bit_valid, bit_ins, hdlc_valid, en_oe}, 8'h01);
    rst_n_i <= 1'b1;
    // table of ordinary cases
    foreach (rows[k])
    begin
      @(posedge clk_i) {hdlc_on, insertable, internal_bit, want, value} <= rows[k][6:2];
      run_op(1, rows[k][1], rows[k][0]);
    end
    // back-to-back announcements
    @(posedge clk_i) {hdlc_on, insertable, internal_bit, want, value} <= 5'h0b;
    run_op(2, 1'b1, 1'b1);
    // hdlc slices on the shared pins
    @(posedge clk_i) hdlc_on <= 1'b1;
    foreach (rows[k])
    begin
      @(posedge clk_i) {bench_en, hdlc_bits} <= rows[k][4:2];
      repeat (2) @(posedge tx_clk);
      i = 0;
      do
      begin
        @(negedge clk_i);
        i++;
      end
      while (hdlc_valid !== 1'b1 && i < 20);
      check({7'h0, hdlc_valid}, 8'h01);
      check({5'h0, hdlc_data}, {5'h0, rows[k][4:2]});
      check({7'h0, en_oe}, 8'h00);
    end
    // reset in mid-announcement clears the port
    @(posedge clk_i) hdlc_on <= 1'b0;
    @(posedge tx_clk);
    @(posedge clk_i) announce <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b0;
    @(negedge clk_i);
    check({5'h0, en_out, oh_clk, bit_valid}, 8'h00);
    // release again and show the port works after a mid-run reset
    @(posedge clk_i) announce <= 1'b0;
    @(posedge clk_i) rst_n_i <= 1'b1;
    run_op(1, 1'b1, 1'b1);
    report_and_stop();
  end
endmodule : tb_top
